//--- core/wdts_watchdog.sv
// watchdog timer with sleep modes and an ahb-lite register slave
// Contract
// R1 - time-out of running watchdog resets device
// R2 - count runs on low-frequency oscillator tick
// R3 - mode 11 always active, sleep included
// R4 - mode 10 active awake, off asleep
// R5 - mode 01 follows software enable bit
// R6 - mode 00 always off, enable ignored
// R7 - period select resets to two seconds
// R8 - codes 0..18 give ratio 32 doubling
// R9 - reserved codes give ratio 32
// R10 - count cleared by resets, sleep, fail, disable
// R11 - crystal clock holds clear until startup ends
// R12 - oscillator divider change leaves count alone
// R13 - count continues in sleep when enabled
// R14 - sleep time-out wakes, updates status flags
// R15 - control layout, reset 01011 and 0
// R16 - time-out when count reaches selected ratio
// R17 - pending interrupt makes sleep a no-op
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "wdts_map.svh"

module wdts_watchdog #(
  parameter int LF_DIV = `WDTS_LF_DIV
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // configuration and processor core
  input  wire logic [1:0]  watchdogModeCfg,
  input  wire logic        watchdogClearInstr,
  input  wire logic        sleepInstr,
  input  wire logic        intPending,
  input  wire logic        wakeEvent,
  // oscillator module
  input  wire logic        oscFail,
  input  wire logic        crystalClock,
  input  wire logic        oscillatorStartupTimer,
  // results
  output logic             watchdogReset,
  output logic             watchdogWake,
  output logic             timeoutFlagN,
  output logic             powerdownFlagN,
  output logic             sleeping,
  output logic             irq
);

  wdts_pkg::wdts_regs_type r_q;
  wdts_pkg::wdts_regs_type r_d;

  logic        active;
  logic        lfTick;
  logic        clearCnt;
  logic        sleepGo;
  logic        sleepNop;
  logic        exitSleep;
  logic        timeout;
  logic [23:0] ratio;
  logic [2:0]  newEvt;
  logic        addrPhase;
  logic [31:0] rdMux;

  // mode decode
  always_comb
  begin
    unique case (wdts_pkg::wdts_mode_type'(watchdogModeCfg))
      // R3 always on
      wdts_pkg::MODE_ON:     active = 1'b1;
      // R4 off in sleep
      wdts_pkg::MODE_NSLEEP: active = (r_q.st != wdts_pkg::ST_SLEEP);
      // R5 software enable
      wdts_pkg::MODE_SOFT:   active = r_q.swEn;
      // R6 always off
      wdts_pkg::MODE_OFF:    active = 1'b0;
    endcase
  end

  // period select to prescale ratio
  always_comb
  begin
    // R9 reserved codes
    if (r_q.period > `WDTS_PS_MAX)
    begin
      ratio = `WDTS_RATIO_MIN;
    end
    else
    begin
      // R8 ratio doubles per code
      ratio = `WDTS_RATIO_MIN << r_q.period;
    end
  end

  // R2 one tick per low-frequency oscillator period
  assign lfTick = (r_q.div == 16'(LF_DIV - 1));

  // sleep requests and exits
  // R17 pending interrupt turns sleep into no-op
  assign sleepNop = sleepInstr && intPending && (r_q.st == wdts_pkg::ST_AWAKE);
  assign sleepGo  = sleepInstr && !intPending && (r_q.st == wdts_pkg::ST_AWAKE);

  // R16 time-out when the count reaches the ratio
  assign timeout = lfTick && active && !clearCnt && ({1'b0, r_q.count} == ratio - 24'h000001);

  assign exitSleep = (r_q.st == wdts_pkg::ST_SLEEP) && (wakeEvent || timeout);

  // R10 clearing conditions
  // R11 held while startup timer waits after exit
  assign clearCnt = watchdogClearInstr || sleepGo || oscFail || !active
                 || (r_q.st == wdts_pkg::ST_OSTW)
                 || ((r_q.st == wdts_pkg::ST_SLEEP) && wakeEvent);

  // events raised this cycle
  always_comb
  begin
    newEvt = 3'h0;
    newEvt[`WDTS_EVT_RESET] = timeout && (r_q.st == wdts_pkg::ST_AWAKE);
    newEvt[`WDTS_EVT_WAKE]  = timeout && (r_q.st == wdts_pkg::ST_SLEEP);
    newEvt[`WDTS_EVT_NOP]   = sleepNop;
  end

  assign addrPhase = hsel && htrans[1] && hready;

  // read data for the address being presented
  always_comb
  begin
    rdMux = 32'h00000000;
    unique case (haddr)
      // R15 bits 7 and 6 read as zero
      `WDTS_CTRL_OFS:  rdMux = {26'h0, r_q.period, r_q.swEn};
      `WDTS_STAT_OFS:  rdMux = {29'h0, r_q.evt};
      `WDTS_IEN_OFS:   rdMux = {29'h0, r_q.ien};
      `WDTS_COUNT_OFS: rdMux = {9'h0, r_q.count};
      `WDTS_STATE_OFS: rdMux = {26'h0, r_q.st, r_q.toN, r_q.pdN, active, 1'b0};
      default:         rdMux = 32'h00000000;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    r_d         = r_q;
    r_d.rstOut  = 1'b0;
    r_d.wakeOut = 1'b0;
    r_d.ready   = 1'b1;

    // free-running oscillator model, back to zero at each tick and at reset
    r_d.div = lfTick ? 16'h0000 : r_q.div + 16'h0001;

    // R12 nothing here reacts to the core clock divider
    // R13 counting goes on in sleep while active
    if (clearCnt)
    begin
      r_d.count = 23'h000000;
    end
    else if (lfTick)
    begin
      r_d.count = timeout ? 23'h000000 : r_q.count + 23'h000001;
    end

    // power state machine
    unique case (r_q.st)
      wdts_pkg::ST_AWAKE:
      begin
        if (sleepGo)
        begin
          r_d.st  = wdts_pkg::ST_SLEEP;
          r_d.toN = 1'b1;
          r_d.pdN = 1'b0;
        end
        else if (timeout)
        begin
          // R1 watchdog time-out resets the device
          r_d.rstOut = 1'b1;
          r_d.toN    = 1'b0;
          r_d.pdN    = 1'b1;
        end
      end
      wdts_pkg::ST_SLEEP:
      begin
        if (exitSleep)
        begin
          // R11 crystal source waits for the startup timer
          r_d.st = crystalClock ? wdts_pkg::ST_OSTW : wdts_pkg::ST_AWAKE;
        end
        if (timeout)
        begin
          // R14 wake instead of reset, flag the time-out
          r_d.wakeOut = 1'b1;
          r_d.toN     = 1'b0;
        end
      end
      wdts_pkg::ST_OSTW:
      begin
        if (!oscillatorStartupTimer)
        begin
          r_d.st = wdts_pkg::ST_AWAKE;
        end
      end
      default:
      begin
        r_d.st = wdts_pkg::ST_AWAKE;
      end
    endcase

    // sleeping comes from its own flop so the pin never shows a decode glitch
    r_d.sleepOut = (r_d.st == wdts_pkg::ST_SLEEP);

    // bus address phase: register a write for its data phase, capture read data
    r_d.wrPend = addrPhase && hwrite;
    r_d.wrAddr = haddr;
    if (addrPhase && !hwrite)
    begin
      r_d.rdata = rdMux;
    end

    // sticky events; a new event beats a clear in the same cycle
    r_d.evt = r_q.evt | newEvt;
    if (r_q.wrPend)
    begin
      unique case (r_q.wrAddr)
        `WDTS_CTRL_OFS:
        begin
          r_d.period = hwdata[`WDTS_PS_MSB:`WDTS_PS_LSB];
          r_d.swEn   = hwdata[`WDTS_EN_BIT];
        end
        `WDTS_IEN_OFS:  r_d.ien = hwdata[2:0];
        `WDTS_ICLR_OFS: r_d.evt = (r_q.evt & ~hwdata[2:0]) | newEvt;
        default:        r_d.ien = r_q.ien;
      endcase
    end

    // R7 own reset restores the two second period
    if (newEvt[`WDTS_EVT_RESET])
    begin
      r_d.period = `WDTS_PS_RST;
      r_d.swEn   = 1'b0;
    end

    // level interrupt from enabled sticky bits
    r_d.irq = |(r_d.evt & r_d.ien);
  end

  // state register, constants only under reset
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r_q.st      <= wdts_pkg::ST_AWAKE;
      // R15 control reset values
      r_q.period  <= `WDTS_PS_RST;
      r_q.swEn    <= 1'b0;
      r_q.evt     <= 3'h0;
      r_q.ien     <= 3'h0;
      // R10 any reset clears the count
      r_q.count   <= 23'h000000;
      r_q.div     <= 16'h0000;
      r_q.toN     <= 1'b1;
      r_q.pdN     <= 1'b1;
      r_q.rstOut  <= 1'b0;
      r_q.wakeOut <= 1'b0;
      r_q.sleepOut <= 1'b0;
      r_q.irq     <= 1'b0;
      r_q.wrPend  <= 1'b0;
      r_q.wrAddr  <= 8'h00;
      r_q.rdata   <= 32'h00000000;
      r_q.ready   <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // outputs straight from flip-flops, hresp tied low
  assign hreadyout      = r_q.ready;
  assign hresp          = 1'b0;
  assign hrdata         = r_q.rdata;
  assign watchdogReset  = r_q.rstOut;
  assign watchdogWake   = r_q.wakeOut;
  assign timeoutFlagN   = r_q.toN;
  assign powerdownFlagN = r_q.pdN;
  assign sleeping       = r_q.sleepOut;
  assign irq            = r_q.irq;

  // hsize is accepted as a full word only; unused bits ignored
  logic unusedBits;
  assign unusedBits = ^{hsize, htrans[0], hwdata[31:6]};

endmodule : wdts_watchdog

//--- core/wdts_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef WDTS_MAP_SVH
`define WDTS_MAP_SVH
// register byte offsets
`define WDTS_CTRL_OFS   8'h00
`define WDTS_STAT_OFS   8'h04
`define WDTS_IEN_OFS    8'h08
`define WDTS_ICLR_OFS   8'h0c
`define WDTS_COUNT_OFS  8'h10
`define WDTS_STATE_OFS  8'h14
// control fields
`define WDTS_EN_BIT     0
`define WDTS_PS_LSB     1
`define WDTS_PS_MSB     5
`define WDTS_PS_RST     5'h0b
`define WDTS_PS_MAX     5'h12
`define WDTS_RATIO_MIN  24'h000020
// event bits
`define WDTS_EVT_RESET  0
`define WDTS_EVT_WAKE   1
`define WDTS_EVT_NOP    2
`define WDTS_EVT_W      3
// clock rates and the low-frequency tick divider
`define WDTS_CLK_HZ     40000000
`define WDTS_LF_HZ      31000
`define WDTS_LF_DIV     (`WDTS_CLK_HZ / `WDTS_LF_HZ)
`endif

//--- core/wdts_pkg.sv
// types of the watchdog block
package wdts_pkg;
  // power state, gray coded along awake, sleep, oscillator wait
  typedef enum logic [1:0]
  {
    ST_AWAKE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OSTW  = 2'b11
  } wdts_state_type;

  typedef enum logic [1:0]
  {
    MODE_OFF    = 2'b00,
    MODE_SOFT   = 2'b01,
    MODE_NSLEEP = 2'b10,
    MODE_ON     = 2'b11
  } wdts_mode_type;

  typedef struct packed {
    wdts_state_type st;
    logic [4:0]     period;
    logic           swEn;
    logic [2:0]     evt;
    logic [2:0]     ien;
    logic [22:0]    count;
    logic [15:0]    div;
    logic           toN;
    logic           pdN;
    logic           rstOut;
    logic           wakeOut;
    logic           sleepOut;
    logic           irq;
    logic           wrPend;
    logic [7:0]     wrAddr;
    logic [31:0]    rdata;
    logic           ready;
  } wdts_regs_type;
endpackage : wdts_pkg

//--- verif/wdts_watchdog_assertions.sv
// port assertions for the watchdog block
`timescale 1ns/10ps
module wdts_checker (
  // clock and reset
  input logic       clock,
  input logic       reset_n,
  // core side
  input logic [1:0] watchdogModeCfg,
  input logic       watchdogClearInstr,
  input logic       sleepInstr,
  input logic       intPending,
  input logic       oscFail,
  // results
  input logic       watchdogReset,
  input logic       watchdogWake,
  input logic       timeoutFlagN,
  input logic       powerdownFlagN,
  input logic       sleeping,
  input logic       irq
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  property p_rst; watchdogReset |-> !timeoutFlagN && powerdownFlagN ##1 !watchdogReset; endproperty
  a_rst: assert property (p_rst) else $error("awake time-out flags wrong");
  property p_wake; watchdogWake |-> !timeoutFlagN && !powerdownFlagN && !sleeping; endproperty
  a_wake: assert property (p_wake) else $error("sleep time-out did not wake");
  property p_off; watchdogModeCfg == 2'h0 && $past(watchdogModeCfg) == 2'h0 |-> !watchdogReset && !watchdogWake; endproperty
  a_off: assert property (p_off) else $error("time-out while mode off");
  property p_nsl; sleeping && watchdogModeCfg == 2'h2 |=> !watchdogWake; endproperty
  a_nsl: assert property (p_nsl) else $error("wake in off-in-sleep mode");
  property p_clr; watchdogClearInstr |=> !watchdogReset && !watchdogWake; endproperty
  a_clr: assert property (p_clr) else $error("clear did not block time-out");
  property p_osc; oscFail |=> !watchdogReset && !watchdogWake; endproperty
  a_osc: assert property (p_osc) else $error("oscillator fail did not clear");
  property p_nop; sleepInstr && intPending && !sleeping |=> !sleeping && $stable(powerdownFlagN); endproperty
  a_nop: assert property (p_nop) else $error("sleep with pending interrupt not skipped");
  property p_slp; sleepInstr && !intPending && !sleeping |=> sleeping && !powerdownFlagN && timeoutFlagN; endproperty
  a_slp: assert property (p_slp) else $error("sleep entry flags wrong");
  // main scenarios reached
  c_rst: cover property (watchdogReset);
  c_wake: cover property (watchdogWake);
  c_irq: cover property ($rose(irq));
endmodule : wdts_checker

bind wdts_watchdog wdts_checker i_chk (.clock(clock), .reset_n(reset_n), .watchdogModeCfg(watchdogModeCfg),
  .watchdogClearInstr(watchdogClearInstr), .sleepInstr(sleepInstr), .intPending(intPending), .oscFail(oscFail),
  .watchdogReset(watchdogReset), .watchdogWake(watchdogWake), .timeoutFlagN(timeoutFlagN),
  .powerdownFlagN(powerdownFlagN), .sleeping(sleeping), .irq(irq));

//--- verif/wdts_core_model.sv
// processor core model issuing clear, sleep and wake strobes
`timescale 1ns/10ps
module wdts_core_model (
  // clock
  input wire logic clock,
  // strobes toward the watchdog
  output logic     clearInstr,
  output logic     sleepInstr,
  output logic     intPending,
  output logic     wakeEvent
);
  // idle low until the bench asks
  initial
  begin
    clearInstr = 1'h0;
    sleepInstr = 1'h0;
    intPending = 1'h0;
    wakeEvent = 1'h0;
  end
  // one-cycle strobe: 0 clear, 1 sleep, 2 wake; pending is a level and stays
  task automatic pulse(input int op, input logic pend);
    @(posedge clock);
    clearInstr <= op == 0;
    sleepInstr <= op == 1;
    wakeEvent <= op == 2;
    intPending <= pend;
    @(posedge clock);
    clearInstr <= 1'h0;
    sleepInstr <= 1'h0;
    wakeEvent <= 1'h0;
  endtask : pulse
endmodule : wdts_core_model

//--- verif/watchdog_timer_with_sleep_modes_test.sv
// self-checking bench for the watchdog block
`timescale 1ns/10ps
`include "wdts_map.svh"
module watchdog_timer_with_sleep_modes_test;
  localparam int D = 4;
  logic        clock, reset_n, hsel, hwrite, oscFail, clr, slp, pend, wake;
  logic        hready, hresp, wdRst, wdWake, sleeping, irq, toN, pdN, xtal, oscillator_startup_timer;
  logic [1:0]  htrans, mode;
  logic [7:0]  haddr;
  logic [31:0] hwdata, hrdata, q;
  int          num_errors, checked;

  wdts_watchdog #(.LF_DIV(D)) i_dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .watchdogModeCfg(mode), .watchdogClearInstr(clr), .sleepInstr(slp),
    .intPending(pend), .wakeEvent(wake), .oscFail(oscFail), .crystalClock(xtal), .oscillatorStartupTimer(oscillator_startup_timer),
    .watchdogReset(wdRst), .watchdogWake(wdWake), .timeoutFlagN(toN), .powerdownFlagN(pdN), .sleeping(sleeping),
    .irq(irq));
  wdts_core_model i_core (.clock(clock), .clearInstr(clr), .sleepInstr(slp), .intPending(pend), .wakeEvent(wake));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("BAD %s expected %h seen %h", what, exp, seen);
  endtask : chk

  // one single ahb transfer, waiting on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'h1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'h1);
    r = hrdata;
  endtask : xfer

  task automatic t_regs;
    xfer(1'h0, `WDTS_CTRL_OFS, 32'h0, q);
    chk("ctrl reset", q, 32'h16);
    chk("resp", hresp, 32'h0);
    xfer(1'h1, `WDTS_CTRL_OFS, 32'hffffffff, q);
    xfer(1'h0, `WDTS_CTRL_OFS, 32'h0, q);
    chk("ctrl bits", q, 32'h3f);
    xfer(1'h0, 8'h20, 32'h0, q);
    chk("unmapped", q, 32'h0);
    oscFail <= 1'h1;
    @(posedge clock);
    oscFail <= 1'h0;
    $display("regs test done");
  endtask : t_regs

  // each row: mode, control word, outcome (0 none, 1 reset, 2 wake); rows 5..7 go to sleep
  task automatic t_modes;
    logic [1:0] md [8] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1};
    logic [7:0] ct [8] = '{8'h02, 8'h00, 8'h27, 8'h00, 8'h01, 8'h00, 8'h01, 8'h3f};
    logic [1:0] ex [8] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2};
    int n, r, got;
    for (int i = 0; i < 8; i++)
    begin
      n = 0;
      r = (i == 0) ? 64 : 32;
      mode <= md[i];
      xfer(1'h1, `WDTS_CTRL_OFS, {24'h0, ct[i]}, q);
      i_core.pulse((i >= 5) ? 1 : 0, 1'h0);
      while (wdRst !== 1'h1 && wdWake !== 1'h1 && n < r * D + 8)
      begin
        @(posedge clock);
        n++;
      end
      got = (wdRst === 1'h1) ? 1 : ((wdWake === 1'h1) ? 2 : 0);
      chk("outcome", got, ex[i]);
      if (ex[i] != 0) chk("period", n >= (r - 2) * D && n <= r * D + 2, 32'h1);
      if (ex[i] != 0) chk("flags", {30'h0, toN, pdN}, (ex[i] == 1) ? 32'h1 : 32'h0);
      if (sleeping === 1'h1) i_core.pulse(2, 1'h0);
    end
    mode <= 2'h0;
    $display("modes test done");
  endtask : t_modes

  task automatic t_irq;
    xfer(1'h0, `WDTS_STAT_OFS, 32'h0, q);
    chk("status", q, 32'h3);
    chk("irq masked", irq, 32'h0);
    xfer(1'h1, `WDTS_IEN_OFS, 32'h3, q);
    repeat (2) @(posedge clock);
    chk("irq on", irq, 32'h1);
    xfer(1'h1, `WDTS_ICLR_OFS, 32'h3, q);
    repeat (2) @(posedge clock);
    chk("irq off", irq, 32'h0);
    $display("irq test done");
  endtask : t_irq

  task automatic t_nop;
    i_core.pulse(1, 1'h1);
    @(posedge clock);
    chk("no sleep", sleeping, 32'h0);
    xfer(1'h0, `WDTS_STAT_OFS, 32'h0, q);
    chk("nop event", q, 32'h4);
    chk("nop flags", {30'h0, toN, pdN}, 32'h0);
    $display("nop test done");
  endtask : t_nop

  // crystal wake holds the count until the startup timer ends; a failure clears it
  task automatic t_ost;
    int n;
    n = 0;
    mode <= 2'h3;
    xtal <= 1'h1;
    oscillator_startup_timer <= 1'h1;
    xfer(1'h1, `WDTS_CTRL_OFS, 32'h0, q);
    i_core.pulse(1, 1'h0);
    while (wdWake !== 1'h1 && n < 32 * D + 8)
    begin
      @(posedge clock);
      n++;
    end
    chk("ost wake", wdWake, 32'h1);
    repeat (4 * D) @(posedge clock);
    xfer(1'h0, `WDTS_STATE_OFS, 32'h0, q);
    chk("ost state", q, 32'h32);
    xfer(1'h0, `WDTS_COUNT_OFS, 32'h0, q);
    chk("ost count", q, 32'h0);
    oscillator_startup_timer <= 1'h0;
    repeat (4 * D) @(posedge clock);
    xfer(1'h0, `WDTS_STATE_OFS, 32'h0, q);
    chk("awake state", q, 32'h2);
    xfer(1'h0, `WDTS_COUNT_OFS, 32'h0, q);
    chk("counting", q != 0, 32'h1);
    oscFail <= 1'h1;
    @(posedge clock);
    xfer(1'h0, `WDTS_COUNT_OFS, 32'h0, q);
    chk("fail clears", q, 32'h0);
    oscFail <= 1'h0;
    {mode, xtal} <= '0;
    $display("ost test done");
  endtask : t_ost

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // free-running 40 MHz clock
  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  // hang guard, far beyond the roughly 1400 cycles needed
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    summarize;
  end

  // main sequence
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, mode, oscFail, xtal, oscillator_startup_timer, reset_n} = '0;
    num_errors = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    @(posedge clock);
    t_regs;
    t_modes;
    t_irq;
    t_nop;
    t_ost;
    summarize;
  end
endmodule : watchdog_timer_with_sleep_modes_test
